// ===== hw/cam_regs.svh
`ifndef CAM_REGS_SVH
`define CAM_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------------
`define CAM_OFF_GMASK_UP 12'h000
`define CAM_OFF_GMASK_LO 12'h004
`define CAM_OFF_BMASK_UP 12'h008
`define CAM_OFF_BMASK_LO 12'h00C
`define CAM_OFF_INT_EN 12'h010
`define CAM_OFF_INT_PEND 12'h014
`define CAM_OFF_INT_CLR 12'h018
`define CAM_OFF_CODE_EN 12'h01C
`define CAM_OFF_STATUS 12'h020
`define CAM_OFF_ERR_CNT 12'h024
`define CAM_OFF_CONFIG 12'h028

// ----------------------------------------------------------------------------
// Field positions, reset values and constants.
// ----------------------------------------------------------------------------
`define CAM_ERR_BIT 15
`define CAM_CFG_EIT_BIT 0
`define CAM_RST_REG16 16'h0000
`define CAM_RST_NS 3'h0
`define CAM_STD_CARE 32'hFFF80000
`define CAM_EXT_CARE 32'hFFFFFFFF
`define CAM_BASIC_BUF 4'hE
`define CAM_IST_ERR 4'h0
`define CAM_RDATA_ZERO 32'h00000000

`endif

// ===== hw/cam_pkg.sv
package cam_pkg;

  // --------------------------------------------------------------------------
  // Identifier in mask layout: the struct packs to the same 32-bit order
  // as the concatenation of the upper and lower mask words.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [10:0] id_hi;
    logic base_rtr;
    logic ide;
    logic [17:0] id_lo;
    logic ext_rtr;
  } cam_frame_t;

  typedef struct packed {
    logic [7:0] reserved;
    logic [2:0] node_state;
    logic irq_valid;
    logic [3:0] irq_source_code;
  } cam_status_t;

  typedef struct packed {
    logic irq_valid;
    logic [3:0] irq_source_code;
  } cam_code_t;

endpackage

// ===== hw/cam_top.sv
`timescale 1ns/1ps
`include "cam_regs.svh"

// Function
// - Clear mask bit: incoming bit must equal buffer identifier bit to accept.
// - Set mask bit: don't care; accepted frame overwrites that buffer bit.
// - Extended frames use mask bits 28..0, extension and both remote masks.
// - Standard frames use only bits 28..18, base remote and extension masks.
// - Bits 28:18 map to ID 10:0 standard; remote masks map RTR/SRR/RTR.
// - A separate basic mask qualifies matching for buffer 14 only.
// - Extended frames on buffer 14 use every basic mask bit.
// - Standard frames on buffer 14 use basic bits 28..18, remote, extension.
// - Each mask is two 16-bit words in the documented bit layout.
// - Enable bit 15 gates the error interrupt onto the interrupt output.
// - Enable bits 14:0 gate buffer n as an interrupt source.
// - Pending bit n sets after successful transfer through buffer n.
// - Error pending sets on a bus error (type 0) or a state change on increment (type 1); software clears it.
// - Writing 1 to clear bit n resets buffer pending n; 0 leaves it.
// - Writing 1 to clear bit 15 resets error pending; 0 leaves it.
// - Code enable decides per source whether pending enters the code.
// - Code: zero if none, valid with 0 for error, n+1 for buffer n.
// - Node status reads 000, 010, 011, 10x, 11x for the five states.
// - Status is read-only: 15:8 zero, node state, valid, source field.
// - Error type 0 flags every bus error, else state change on increment.
// - Eight-bit receive and transmit error counters drive the error flag only with error type 1.
module cam_top
  import cam_pkg::*;
#(
  parameter int NUM_BUF = 15,
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_check,
  input wire cam_frame_t rx_frame,
  input wire logic [3:0] rx_buf_idx,
  input wire cam_frame_t buf_frame,
  output logic acc_done,
  output logic acc_hit,
  output logic [3:0] acc_buf,
  output cam_frame_t acc_frame,
  input wire logic [NUM_BUF-1:0] buf_done,
  input wire logic bus_error,
  input wire logic [7:0] rx_error_count,
  input wire logic [7:0] tx_error_count,
  input wire logic [2:0] node_state,
  output logic can_irq
);

  // --------------------------------------------------------------------------
  // Functions.
  // --------------------------------------------------------------------------
  function automatic logic [31:0] care_fn(input logic ext);
    care_fn = ext ? `CAM_EXT_CARE : `CAM_STD_CARE;
  endfunction

  function automatic cam_code_t code_fn(input logic [15:0] req);
    cam_code_t c;
    c = '0;
    if (req[`CAM_ERR_BIT])
    begin
      c.irq_valid = 1'b1;
      c.irq_source_code = `CAM_IST_ERR;
    end
    else
    begin
      for (int i = 14; i >= 0; i--)
      begin
        if (req[i])
        begin
          c.irq_valid = 1'b1;
          c.irq_source_code = 4'(i + 1);
        end
      end
    end
    code_fn = c;
  endfunction

  function automatic logic addr_ok_fn(input logic [ADDR_W-1:0] a);
    addr_ok_fn = (a == `CAM_OFF_GMASK_UP) || (a == `CAM_OFF_GMASK_LO) ||
                 (a == `CAM_OFF_BMASK_UP) || (a == `CAM_OFF_BMASK_LO) ||
                 (a == `CAM_OFF_INT_EN) || (a == `CAM_OFF_INT_PEND) ||
                 (a == `CAM_OFF_INT_CLR) || (a == `CAM_OFF_CODE_EN) ||
                 (a == `CAM_OFF_STATUS) || (a == `CAM_OFF_ERR_CNT) ||
                 (a == `CAM_OFF_CONFIG);
  endfunction

  // --------------------------------------------------------------------------
  // Register storage.
  // --------------------------------------------------------------------------
  logic [15:0] global_mask_upper_r;
  logic [15:0] global_mask_lower_r;
  logic [15:0] buffer14_mask_upper_r;
  logic [15:0] buffer14_mask_lower_r;
  logic [15:0] interrupt_enable_r;
  logic [15:0] interrupt_pending_r;
  logic [15:0] interrupt_pending_nxt;
  logic [15:0] interrupt_code_enable_r;
  logic error_irq_type_r;
  cam_code_t code_r;
  logic [2:0] node_state_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // --------------------------------------------------------------------------
  // APB slave.
  // --------------------------------------------------------------------------
  // The answer is one wait state long, so read data and the error flag come
  // straight from flip-flops instead of a combinational decode path.
  logic acc_phase;
  logic wr_en;
  logic [31:0] rdata_nxt;
  assign acc_phase = psel & penable & ~pready_r;
  assign wr_en = psel & penable & pready_r & pwrite;

  always_comb
  begin
    rdata_nxt = `CAM_RDATA_ZERO;
    unique case (paddr)
      `CAM_OFF_GMASK_UP: rdata_nxt[15:0] = global_mask_upper_r;
      `CAM_OFF_GMASK_LO: rdata_nxt[15:0] = global_mask_lower_r;
      `CAM_OFF_BMASK_UP: rdata_nxt[15:0] = buffer14_mask_upper_r;
      `CAM_OFF_BMASK_LO: rdata_nxt[15:0] = buffer14_mask_lower_r;
      `CAM_OFF_INT_EN: rdata_nxt[15:0] = interrupt_enable_r;
      `CAM_OFF_INT_PEND: rdata_nxt[15:0] = interrupt_pending_r;
      `CAM_OFF_CODE_EN: rdata_nxt[15:0] = interrupt_code_enable_r;
      `CAM_OFF_STATUS: rdata_nxt[15:0] = cam_status_t'({8'h00, node_state_r, code_r});
      `CAM_OFF_ERR_CNT: rdata_nxt[15:0] = {rx_error_count, tx_error_count};
      `CAM_OFF_CONFIG: rdata_nxt[`CAM_CFG_EIT_BIT] = error_irq_type_r;
      default: rdata_nxt = `CAM_RDATA_ZERO;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `CAM_RDATA_ZERO;
    end
    else
    begin
      pready_r <= acc_phase;
      pslverr_r <= acc_phase & ~addr_ok_fn(paddr);
      if (acc_phase && !pwrite)
      begin
        prdata_r <= rdata_nxt;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // --------------------------------------------------------------------------
  // Configuration registers.
  // --------------------------------------------------------------------------
  // One strobe per register keeps every register in a block of its own.
  logic wr_gmask_up;
  logic wr_gmask_lo;
  logic wr_bmask_up;
  logic wr_bmask_lo;
  logic wr_int_en;
  logic wr_code_en;
  logic wr_config;

  assign wr_gmask_up = wr_en && (paddr == `CAM_OFF_GMASK_UP);
  assign wr_gmask_lo = wr_en && (paddr == `CAM_OFF_GMASK_LO);
  assign wr_bmask_up = wr_en && (paddr == `CAM_OFF_BMASK_UP);
  assign wr_bmask_lo = wr_en && (paddr == `CAM_OFF_BMASK_LO);
  assign wr_int_en = wr_en && (paddr == `CAM_OFF_INT_EN);
  assign wr_code_en = wr_en && (paddr == `CAM_OFF_CODE_EN);
  assign wr_config = wr_en && (paddr == `CAM_OFF_CONFIG);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      global_mask_upper_r <= `CAM_RST_REG16;
    end
    else if (wr_gmask_up)
    begin
      global_mask_upper_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      global_mask_lower_r <= `CAM_RST_REG16;
    end
    else if (wr_gmask_lo)
    begin
      global_mask_lower_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buffer14_mask_upper_r <= `CAM_RST_REG16;
    end
    else if (wr_bmask_up)
    begin
      buffer14_mask_upper_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buffer14_mask_lower_r <= `CAM_RST_REG16;
    end
    else if (wr_bmask_lo)
    begin
      buffer14_mask_lower_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      interrupt_enable_r <= `CAM_RST_REG16;
    end
    else if (wr_int_en)
    begin
      interrupt_enable_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      interrupt_code_enable_r <= `CAM_RST_REG16;
    end
    else if (wr_code_en)
    begin
      interrupt_code_enable_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      error_irq_type_r <= 1'b0;
    end
    else if (wr_config)
    begin
      error_irq_type_r <= pwdata[`CAM_CFG_EIT_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Acceptance filter.
  // --------------------------------------------------------------------------
  // The receive path presents one candidate buffer per check; scanning all
  // buffers stays outside so the mask logic is a single comparator.
  logic [31:0] use_mask;
  logic [31:0] eff_mask;
  logic [31:0] rx_vec;
  logic [31:0] buf_vec;
  logic match;
  logic [31:0] merged;

  always_comb
  begin
    rx_vec = rx_frame;
    buf_vec = buf_frame;
    if (rx_buf_idx == `CAM_BASIC_BUF)
    begin
      use_mask = {buffer14_mask_upper_r, buffer14_mask_lower_r};
    end
    else
    begin
      use_mask = {global_mask_upper_r, global_mask_lower_r};
    end
    // Standard frames drop the low identifier and extended remote bits.
    eff_mask = care_fn(rx_frame.ide);
    match = (((rx_vec ^ buf_vec) & ~use_mask & eff_mask) == 32'h00000000);
    merged = (buf_vec & ~(use_mask & eff_mask)) | (rx_vec & use_mask & eff_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_done <= 1'b0;
      acc_hit <= 1'b0;
      acc_buf <= 4'h0;
      acc_frame <= '0;
    end
    else
    begin
      acc_done <= rx_check;
      if (rx_check)
      begin
        acc_hit <= match;
        acc_buf <= rx_buf_idx;
        acc_frame <= cam_frame_t'(merged);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Error event detection.
  // --------------------------------------------------------------------------
  logic [7:0] rec_prev_r;
  logic [7:0] tec_prev_r;
  logic cnt_inc;
  logic err_event;

  assign cnt_inc = (rx_error_count > rec_prev_r) || (tx_error_count > tec_prev_r);

  always_comb
  begin
    if (!error_irq_type_r)
    begin
      err_event = bus_error;
    end
    else
    begin
      err_event = cnt_inc && (node_state != node_state_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rec_prev_r <= 8'h00;
      tec_prev_r <= 8'h00;
      node_state_r <= `CAM_RST_NS;
    end
    else
    begin
      rec_prev_r <= rx_error_count;
      tec_prev_r <= tx_error_count;
      node_state_r <= node_state;
    end
  end

  // --------------------------------------------------------------------------
  // Pending flags and interrupt code.
  // --------------------------------------------------------------------------
  logic [15:0] clr_vec;
  logic [15:0] set_vec;

  assign clr_vec = (wr_en && paddr == `CAM_OFF_INT_CLR) ? pwdata[15:0] : 16'h0000;
  assign set_vec = {err_event, buf_done};
  // Set beats clear so that an event landing on the clear write is kept.
  assign interrupt_pending_nxt = (interrupt_pending_r & ~clr_vec) | set_vec;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      interrupt_pending_r <= `CAM_RST_REG16;
      code_r <= '0;
      can_irq <= 1'b0;
    end
    else
    begin
      interrupt_pending_r <= interrupt_pending_nxt;
      code_r <= code_fn(interrupt_pending_nxt & interrupt_code_enable_r);
      can_irq <= |(interrupt_pending_nxt & interrupt_enable_r);
    end
  end

endmodule // cam_top

// ===== testbench/cam_evt_model.sv
`timescale 1ns/1ps
module cam_evt_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [14:0] done_req,
  input wire logic err_req,
  input wire logic step,
  input wire logic [2:0] new_state,
  output logic [14:0] buf_done,
  output logic bus_error,
  output logic [7:0] rx_error_count,
  output logic [7:0] tx_error_count,
  output logic [2:0] node_state
);
  // Transfer success and bus errors are single-cycle pulses.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {buf_done, bus_error} <= 16'h0000;
    else
      {buf_done, bus_error} <= {done_req, err_req};
  // The counter step and the state change land on one edge.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {rx_error_count, tx_error_count, node_state} <= 19'h00000;
    else if (step)
      {rx_error_count, tx_error_count, node_state} <=
        {rx_error_count + 8'h01, tx_error_count + 8'h01, new_state};
endmodule // cam_evt_model

// ===== testbench/cam_top_properties.sv
`timescale 1ns/1ps
module cam_chk
  import cam_pkg::*;
#(
  parameter int NUM_BUF = 15,
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_check,
  input wire cam_frame_t rx_frame,
  input wire cam_frame_t buf_frame,
  input wire logic acc_done,
  input wire logic acc_hit,
  input wire cam_frame_t acc_frame,
  input wire logic [NUM_BUF-1:0] buf_done,
  input wire logic bus_error,
  input wire logic [2:0] node_state,
  input wire logic can_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd_ack = psel && penable && pready && !pwrite;
  logic [2:0] ns_q;
  logic cause_q;
  logic wr_q;
  always_ff @(posedge pclk)
    ns_q <= node_state;
  always_ff @(posedge pclk)
    cause_q <= |buf_done || bus_error || wr_q || node_state != ns_q;
  always_ff @(posedge pclk)
    wr_q <= psel && pwrite && pready;
  AST_PREADY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_STATUS_RSVD: assert property (rd_ack && paddr == 12'h020 |-> prdata[31:8] == 24'h000000)
    else $error("status reserved bits set");
  AST_CLEAR_READ_ZERO: assert property (rd_ack && paddr == 12'h018 |-> prdata == 32'h00000000)
    else $error("clear register not zero");
  AST_ACC_TIMING: assert property (acc_done == $past(rx_check))
    else $error("acc_done timing");
  AST_EQUAL_HITS: assert property (rx_check && rx_frame == buf_frame |=> acc_hit && acc_frame == $past(buf_frame))
    else $error("equal frame refused");
  AST_IRQ_RISE: assert property ($past(presetn) && $rose(can_irq) |-> cause_q)
    else $error("irq rose without cause");
  AST_IRQ_FALL: assert property ($past(presetn) && $fell(can_irq) |-> wr_q)
    else $error("irq fell without write");
  cover property (rx_check ##1 acc_hit);
  cover property ($rose(can_irq));
  cover property (pslverr);
endmodule // cam_chk

bind cam_top cam_chk #(.NUM_BUF(NUM_BUF), .ADDR_W(ADDR_W)) chk_i (.*);

// ===== testbench/cam_top_tb.sv
`timescale 1ns/1ps
`include "cam_regs.svh"
module cam_top_tb
  import cam_pkg::*;
;
  typedef struct packed {
    logic [31:0] gm;
    logic [31:0] bm;
    logic [31:0] rx;
    logic [31:0] bf;
    logic [3:0] idx;
    logic hit;
  } cam_row_t;
  localparam logic [31:0] EF = 32'hA5A83C3D;
  localparam logic [31:0] SF = 32'hA5A00000;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic rx_check = 1'b0, err_req = 1'b0, step = 1'b0, pready, pslverr, acc_done, acc_hit;
  logic can_irq, bus_error, rd_e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd_d;
  logic [3:0] rx_buf_idx = 4'h0, acc_buf;
  cam_frame_t rx_frame = '0, buf_frame = '0, acc_frame;
  logic [14:0] buf_done, done_req = 15'h0000;
  logic [7:0] rx_error_count, tx_error_count;
  logic [2:0] node_state, new_state = 3'h0;
  int fail_count = 0, compares = 0;
  // Rows: gm, bm, rx, bf, idx, hit ...
  cam_row_t rows [12] = '{
    '{32'h0, 32'h0, EF, EF, 4'h0, 1'b1}, '{32'h0, 32'h0, EF ^ 32'h1, EF, 4'h1, 1'b0},
    '{32'h1, 32'h0, EF ^ 32'h1, EF, 4'h2, 1'b1},
    '{32'h00100000, 32'h0, EF ^ 32'h00100000, EF, 4'h3, 1'b1},
    '{32'h0, 32'h0, SF ^ 32'h00200000, SF, 4'h4, 1'b0},
    '{32'h00200000, 32'h0, SF ^ 32'h00200000, SF, 4'h5, 1'b1},
    '{32'h0007FFFF, 32'h0, SF ^ 32'h02000000, SF, 4'h6, 1'b0},
    '{32'h0, 32'h0, SF ^ 32'h00000001, SF, 4'h7, 1'b1},
    '{32'hFFFFFFFF, 32'h0, EF ^ 32'h1, EF, 4'hE, 1'b0},
    '{32'h0, 32'hFFFFFFFF, EF ^ 32'h1, EF, 4'hD, 1'b0},
    '{32'h0, 32'h40000000, SF ^ 32'h40000000, SF, 4'hE, 1'b1},
    '{32'h0, 32'h00000002, EF ^ 32'h2, EF, 4'hE, 1'b1}};
  always #5 pclk = ~pclk;
  cam_top uut (.*);
  cam_evt_model far (.*);
  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fail_count++;
      results();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("prdata", exp, rd_d);
  endtask
  task automatic irq(input logic exp);
    repeat (2) @(negedge pclk);
    chk("can_irq", {31'h0, exp}, {31'h0, can_irq});
  endtask
  // Events are asked of the far-side model, which pulses them one edge later.
  task automatic ev(input logic [14:0] d, input logic e, input logic s, input logic [2:0] ns);
    @(posedge pclk);
    done_req <= d;
    err_req <= e;
    step <= s;
    new_state <= ns;
    @(posedge pclk);
    done_req <= 15'h0000;
    err_req <= 1'b0;
    step <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  initial
  begin
    cam_row_t r;
    logic [31:0] m;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++)
      rd(12'(4 * i), 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk("pslverr", 32'h1, {31'h0, rd_e});
    foreach (rows[i])
    begin
      r = rows[i];
      apb(1'b1, `CAM_OFF_GMASK_UP, {16'h0000, r.gm[31:16]});
      apb(1'b1, `CAM_OFF_GMASK_LO, {16'h0000, r.gm[15:0]});
      apb(1'b1, `CAM_OFF_BMASK_UP, {16'h0000, r.bm[31:16]});
      apb(1'b1, `CAM_OFF_BMASK_LO, {16'h0000, r.bm[15:0]});
      @(posedge pclk);
      rx_check <= 1'b1;
      rx_frame <= r.rx;
      buf_frame <= r.bf;
      rx_buf_idx <= r.idx;
      @(posedge pclk);
      rx_check <= 1'b0;
      @(posedge pclk);
      m = (r.idx == `CAM_BASIC_BUF ? r.bm : r.gm) & (r.rx[19] ? `CAM_EXT_CARE : `CAM_STD_CARE);
      chk("acc_hit", {31'h0, r.hit}, {31'h0, acc_hit});
      chk("acc_buf", {28'h0, r.idx}, {28'h0, acc_buf});
      if (r.hit)
        chk("acc_frame", (r.bf & ~m) | (r.rx & m), acc_frame);
    end
    rd(`CAM_OFF_BMASK_LO, 32'h2);
    apb(1'b1, `CAM_OFF_CODE_EN, 32'hFFFF);
    apb(1'b1, `CAM_OFF_INT_EN, 32'h0008);
    ev(15'h0028, 1'b0, 1'b0, 3'h0);
    rd(`CAM_OFF_INT_PEND, 32'h0028);
    rd(`CAM_OFF_STATUS, 32'h14);
    irq(1'b1);
    apb(1'b1, `CAM_OFF_INT_CLR, 32'h0008);
    rd(`CAM_OFF_INT_PEND, 32'h0020);
    rd(`CAM_OFF_STATUS, 32'h16);
    irq(1'b0);
    apb(1'b1, `CAM_OFF_CODE_EN, 32'hFFDF);
    rd(`CAM_OFF_STATUS, 32'h0);
    ev(15'h0000, 1'b1, 1'b0, 3'h0);
    rd(`CAM_OFF_INT_PEND, 32'h8020);
    rd(`CAM_OFF_STATUS, 32'h10);
    irq(1'b0);
    apb(1'b1, `CAM_OFF_INT_EN, 32'h8000);
    irq(1'b1);
    apb(1'b1, `CAM_OFF_INT_CLR, 32'h0000);
    rd(`CAM_OFF_INT_PEND, 32'h8020);
    apb(1'b1, `CAM_OFF_INT_CLR, 32'h8000);
    rd(`CAM_OFF_INT_PEND, 32'h0020);
    apb(1'b1, `CAM_OFF_CONFIG, 32'h1);
    rd(`CAM_OFF_CONFIG, 32'h1);
    ev(15'h0000, 1'b1, 1'b0, 3'h0);
    rd(`CAM_OFF_INT_PEND, 32'h0020);
    ev(15'h0000, 1'b0, 1'b1, 3'h2);
    rd(`CAM_OFF_INT_PEND, 32'h8020);
    rd(`CAM_OFF_STATUS, 32'h50);
    rd(`CAM_OFF_ERR_CNT, 32'h0101);
    apb(1'b1, `CAM_OFF_CODE_EN, 32'hFFFF);
    rd(`CAM_OFF_STATUS, 32'h50);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    irq(1'b0);
    rd(`CAM_OFF_INT_PEND, 32'h0);
    rd(`CAM_OFF_BMASK_LO, 32'h0);
    rd(`CAM_OFF_CONFIG, 32'h0);
    results();
  end
endmodule // cam_top_tb
